// ==== serial_link_self_test_regs.vh ====
// constants of the serial link self-test block
// assumes plain verilog-2005 inclusion by bare name
`ifndef SERIAL_LINK_SELF_TEST_REGS_VH
`define SERIAL_LINK_SELF_TEST_REGS_VH
// register offsets
`define ADDR_TALLY 8'h57
`define ADDR_CTRL 8'hB3
`define ADDR_PAGE 8'h4C
`define CTRL_RESET 8'h00
`define PAGE_RESET 8'h00
// control fields
`define CTRL_EN_BIT 0
`define CTRL_CLK_HI 2
`define CTRL_CLK_LO 1
`define CTRL_GATE_HI 7
`define CTRL_GATE_LO 6
`define GATE_ON 2'b10
`define PAGE_PORT_BIT 4
// tally values
`define TALLY_FAIL 8'hFF
`define TALLY_MAX 8'hFE
`define TALLY_ZERO 8'h00
// remote serializer clock-select register
`define SER_CLK_REG 8'h14
`define SER_RUN_BIT 8'h01
`define SER_CLK_SHIFT 1
// prbs word width
`define WORD_W 8
`endif

// ==== serial_link_self_test.v ====
// serial_link_self_test: receiver-side control of the link self test
// assumes rx words, lock and back-channel ack come from logic on CLK_IN;
// the start pin and the two clock-select pins are asynchronous.
// Functional notes
// - start self test on pin high or on control register enable bit
// - on start, write serializer over back channel to enter self test
// - detect received prbs and flag every mismatching word as error
// - lock, pass and monitor outputs keep working during the test
// - each receive port keeps a readable self-test error tally
// - tally reads all ones on no or lost lock; else saturates one below
// - pin start forwards two pin levels to serializer clock-select bits
// - sample the clock-select pins once, on the start pin rise
// - register start forwards test_clock_select with same encoding
// - capture test_clock_select only at start; later writes ignored
// - pass pin drives low for every data error on the selected port
// - test_output_gating 00 disables outputs, 10 enables them
// - with outputs on, csi lanes idle lp11 unless pattern gen runs
// - registers reachable from i2c and from the control channel
`timescale 1ns/100ps
`default_nettype none
`include "serial_link_self_test_regs.vh"
module serial_link_self_test (
    // clock, reset, enable
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire CE_IN,
    // pins
    input wire SELF_TEST_PIN_ENABLE_IN,
    input wire [1:0] CLK_SEL_PINS_IN,
    // i2c register access
    input wire [7:0] I2C_ADDR_IN,
    input wire [7:0] I2C_WDATA_IN,
    input wire I2C_WR_IN,
    input wire I2C_RD_IN,
    output reg [7:0] I2C_RDATA_OUT,
    // control channel register access
    input wire [7:0] CC_ADDR_IN,
    input wire [7:0] CC_WDATA_IN,
    input wire CC_WR_IN,
    input wire CC_RD_IN,
    output reg [7:0] CC_RDATA_OUT,
    // back channel write to serializer
    output reg BC_WR_REQ_OUT,
    output reg [7:0] BC_ADDR_OUT,
    output reg [7:0] BC_DATA_OUT,
    input wire BC_WR_ACK_IN,
    // receive ports
    input wire [1:0] RX_LOCK_IN,
    input wire [1:0] RX_VALID_IN,
    input wire [15:0] RX_WORD_IN,
    input wire RX_MON_IN,
    // pin function select and pattern generator
    input wire PASS_PORT_SEL_IN,
    input wire PATGEN_EN_IN,
    // status and gating
    output reg TEST_ACTIVE_OUT,
    output reg [1:0] LOCK_OUT,
    output reg [1:0] PASS_OUT,
    output reg GPIO_PASS_OUT,
    output reg MONITOR_LINE_OUT,
    output reg OUT_EN_OUT,
    output reg CSI_LP11_OUT
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_RUN = 4'b0100;
    localparam [3:0] ST_STOP = 4'b1000;

    reg rst_a_r;
    reg rst_b_r;
    wire rst_n = rst_b_r;
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else if (CE_IN) begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end

    // three-stage pin capture; a level counts once stages two and three agree
    reg [2:0] s1_r;
    reg [2:0] s2_r;
    reg [2:0] s3_r;
    reg [2:0] pin_r;
    wire [2:0] pin_raw = {SELF_TEST_PIN_ENABLE_IN, CLK_SEL_PINS_IN};
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always @(posedge CLK_IN or negedge rst_n) begin
                if (!rst_n) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    pin_r[g] <= 1'b0;
                end else if (CE_IN) begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        pin_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate
    wire pin_en = pin_r[2];
    reg pin_en_d_r;
    wire pin_rise = pin_en && !pin_en_d_r;

    // register file
    reg [7:0] ctrl_r;
    reg [7:0] page_r;
    reg [7:0] tally_r [0:1];
    wire [1:0] gating = ctrl_r[`CTRL_GATE_HI:`CTRL_GATE_LO];
    wire reg_en = ctrl_r[`CTRL_EN_BIT];
    reg reg_en_d_r;
    wire reg_rise = reg_en && !reg_en_d_r;
    wire [7:0] tally_view = tally_r[page_r[`PAGE_PORT_BIT]];

    function [7:0] rd_mux;
        input [7:0] a;
        input [7:0] c;
        input [7:0] p;
        input [7:0] t;
        begin
            case (a)
                `ADDR_CTRL: rd_mux = c;
                `ADDR_PAGE: rd_mux = p;
                `ADDR_TALLY: rd_mux = t;
                default: rd_mux = `TALLY_ZERO;
            endcase
        end
    endfunction

    // i2c write wins over a same-cycle control channel write
    wire wr_any = I2C_WR_IN || CC_WR_IN;
    wire [7:0] wr_addr = I2C_WR_IN ? I2C_ADDR_IN : CC_ADDR_IN;
    wire [7:0] wr_data = I2C_WR_IN ? I2C_WDATA_IN : CC_WDATA_IN;
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
            page_r <= `PAGE_RESET;
            I2C_RDATA_OUT <= `TALLY_ZERO;
            CC_RDATA_OUT <= `TALLY_ZERO;
        end else if (CE_IN) begin
            if (wr_any && wr_addr == `ADDR_CTRL) begin
                ctrl_r <= wr_data;
            end
            if (wr_any && wr_addr == `ADDR_PAGE) begin
                page_r <= wr_data;
            end
            if (I2C_RD_IN) begin
                I2C_RDATA_OUT <= rd_mux(I2C_ADDR_IN, ctrl_r, page_r, tally_view);
            end
            if (CC_RD_IN) begin
                CC_RDATA_OUT <= rd_mux(CC_ADDR_IN, ctrl_r, page_r, tally_view);
            end
        end
    end

    // sequencer
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg by_pin_r;
    reg [1:0] clk_sel_r;
    wire start_req = pin_rise || reg_rise;
    wire src_on = by_pin_r ? pin_en : reg_en;
    always @* begin
        case (state_r)
            ST_IDLE: state_nxt = start_req ? ST_START : ST_IDLE;
            ST_START: state_nxt = BC_WR_ACK_IN ? ST_RUN : ST_START;
            ST_RUN: state_nxt = src_on ? ST_RUN : ST_STOP;
            ST_STOP: state_nxt = BC_WR_ACK_IN ? ST_IDLE : ST_STOP;
            default: state_nxt = ST_IDLE;
        endcase
    end
    wire running = (state_r == ST_RUN);
    wire starting = (state_r == ST_IDLE) && start_req;

    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            pin_en_d_r <= 1'b0;
            reg_en_d_r <= 1'b0;
            by_pin_r <= 1'b0;
            clk_sel_r <= 2'b00;
            BC_WR_REQ_OUT <= 1'b0;
            BC_ADDR_OUT <= `TALLY_ZERO;
            BC_DATA_OUT <= `TALLY_ZERO;
        end else if (CE_IN) begin
            state_r <= state_nxt;
            pin_en_d_r <= pin_en;
            reg_en_d_r <= reg_en;
            if (starting) begin
                by_pin_r <= pin_rise;
                // captured once; later pin or field changes are ignored
                if (pin_rise) begin
                    clk_sel_r <= pin_r[1:0];
                end else begin
                    clk_sel_r <= ctrl_r[`CTRL_CLK_HI:`CTRL_CLK_LO];
                end
            end
            // hold the request until acknowledged
            if (starting) begin
                BC_WR_REQ_OUT <= 1'b1;
                BC_ADDR_OUT <= `SER_CLK_REG;
                BC_DATA_OUT <= `SER_RUN_BIT | ({6'b00_0000,
                    pin_rise ? pin_r[1:0] : ctrl_r[`CTRL_CLK_HI:`CTRL_CLK_LO]}
                    << `SER_CLK_SHIFT);
            end else if (running && !src_on) begin
                BC_WR_REQ_OUT <= 1'b1;
                BC_ADDR_OUT <= `SER_CLK_REG;
                BC_DATA_OUT <= {6'b00_0000, clk_sel_r} << `SER_CLK_SHIFT;
            end else if (BC_WR_ACK_IN) begin
                BC_WR_REQ_OUT <= 1'b0;
            end
        end
    end

    // per-port prbs7 check; each word predicts the next, so no seed exchange
    function [7:0] prbs_next;
        input [7:0] w;
        reg [6:0] s;
        integer i;
        begin
            s = w[6:0];
            prbs_next = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                s = {s[5:0], s[6] ^ s[5]};
                prbs_next[i] = s[0];
            end
        end
    endfunction

    reg [1:0] err_r;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_port
            reg [7:0] prev_r;
            reg seed_r;
            reg seen_lock_r;
            reg lost_r;
            reg [7:0] cnt_r;
            wire [7:0] word = RX_WORD_IN[g*8+7:g*8];
            wire lock = RX_LOCK_IN[g];
            wire chk = running && lock && RX_VALID_IN[g] && seed_r;
            wire bad = chk && (word != prbs_next(prev_r));
            always @(posedge CLK_IN or negedge rst_n) begin
                if (!rst_n) begin
                    prev_r <= `TALLY_ZERO;
                    seed_r <= 1'b0;
                    seen_lock_r <= 1'b0;
                    lost_r <= 1'b0;
                    cnt_r <= `TALLY_ZERO;
                    tally_r[g] <= `TALLY_ZERO;
                    err_r[g] <= 1'b0;
                end else if (CE_IN) begin
                    err_r[g] <= bad;
                    if (starting) begin
                        seed_r <= 1'b0;
                        seen_lock_r <= 1'b0;
                        lost_r <= 1'b0;
                        cnt_r <= `TALLY_ZERO;
                        tally_r[g] <= `TALLY_FAIL;
                    end else if (running) begin
                        if (lock) begin
                            seen_lock_r <= 1'b1;
                        end else if (seen_lock_r) begin
                            lost_r <= 1'b1;
                        end
                        if (!lock) begin
                            seed_r <= 1'b0;
                        end else if (RX_VALID_IN[g]) begin
                            prev_r <= word;
                            seed_r <= 1'b1;
                        end
                        if (bad && cnt_r != `TALLY_MAX) begin
                            cnt_r <= cnt_r + 8'h01;
                        end
                        // tally stays readable after the run ends
                        if (lost_r || !(seen_lock_r || lock) || (seen_lock_r && !lock)) begin
                            tally_r[g] <= `TALLY_FAIL;
                        end else begin
                            tally_r[g] <= (bad && cnt_r != `TALLY_MAX) ?
                                cnt_r + 8'h01 : cnt_r;
                        end
                    end
                end
            end
        end
    endgenerate

    // outputs
    wire gate_on = !running || (gating == `GATE_ON);
    wire [1:0] pass_nxt = running ? ~err_r & RX_LOCK_IN : RX_LOCK_IN;
    always @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            TEST_ACTIVE_OUT <= 1'b0;
            LOCK_OUT <= 2'b00;
            PASS_OUT <= 2'b00;
            GPIO_PASS_OUT <= 1'b0;
            MONITOR_LINE_OUT <= 1'b0;
            OUT_EN_OUT <= 1'b1;
            CSI_LP11_OUT <= 1'b1;
        end else if (CE_IN) begin
            TEST_ACTIVE_OUT <= running;
            LOCK_OUT <= RX_LOCK_IN;
            PASS_OUT <= pass_nxt;
            GPIO_PASS_OUT <= pass_nxt[PASS_PORT_SEL_IN];
            MONITOR_LINE_OUT <= RX_MON_IN;
            OUT_EN_OUT <= gate_on;
            // lanes park in lp11 during the test unless the generator drives them
            CSI_LP11_OUT <= running ? !(gate_on && PATGEN_EN_IN) : 1'b0;
        end
    end
endmodule // serial_link_self_test
`default_nettype wire

// ==== self_test_checker_assertions.sv ====
// checker for the serial link self-test block, bound to its top module
// assumes one clock CLK_IN and the active-low reset RST_N_IN
`timescale 1ns/100ps
`default_nettype none
module self_test_checker (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [1:0] RX_LOCK_IN,
    input wire logic RX_MON_IN,
    input wire logic BC_WR_ACK_IN,
    input wire logic PATGEN_EN_IN,
    input wire logic BC_WR_REQ_OUT,
    input wire logic [7:0] BC_ADDR_OUT,
    input wire logic [7:0] BC_DATA_OUT,
    input wire logic TEST_ACTIVE_OUT,
    input wire logic [1:0] LOCK_OUT,
    input wire logic [1:0] PASS_OUT,
    input wire logic MONITOR_LINE_OUT,
    input wire logic CSI_LP11_OUT,
    input wire logic CE_IN
);
    logic [2:0] up_r;
    logic ok;
    // copies are only owed once the internal reset copy has let go
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h4) begin
            up_r <= up_r + 3'h1;
        end
    end
    assign ok = (up_r == 3'h4);
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    AST_LOCK_COPY: assert property (ok && $past(CE_IN) |-> LOCK_OUT == $past(RX_LOCK_IN))
        else $error("lock output lost");
    AST_MON_COPY: assert property (ok && $past(CE_IN) |-> MONITOR_LINE_OUT == $past(RX_MON_IN))
        else $error("monitor output lost");
    AST_BC_HOLD: assert property (BC_WR_REQ_OUT && !BC_WR_ACK_IN |=>
        BC_WR_REQ_OUT && $stable(BC_ADDR_OUT) && $stable(BC_DATA_OUT))
        else $error("back-channel write not held");
    AST_BC_DROP: assert property (BC_WR_REQ_OUT && BC_WR_ACK_IN && CE_IN |=> !BC_WR_REQ_OUT)
        else $error("back-channel write not released");
    AST_BC_ADDR: assert property (BC_WR_REQ_OUT |-> BC_ADDR_OUT == 8'h14)
        else $error("wrong serializer register");
    // run state is entered on the ack edge, the status flop follows one edge later
    AST_RUN_AFTER_ACK: assert property (BC_WR_REQ_OUT && BC_WR_ACK_IN && BC_DATA_OUT[0]
        |=> ##1 TEST_ACTIVE_OUT)
        else $error("test not running after start write");
    AST_STOP_AFTER_ACK: assert property (BC_WR_REQ_OUT && BC_WR_ACK_IN && !BC_DATA_OUT[0]
        |=> !TEST_ACTIVE_OUT)
        else $error("test still running after stop write");
    AST_LP11_IDLE: assert property (TEST_ACTIVE_OUT && $past(TEST_ACTIVE_OUT)
        && !$past(PATGEN_EN_IN) |-> CSI_LP11_OUT)
        else $error("lanes not idle");
    AST_PASS_LOCK: assert property (TEST_ACTIVE_OUT && $past(TEST_ACTIVE_OUT)
        && !LOCK_OUT[0] && !$past(LOCK_OUT[0]) |-> !PASS_OUT[0])
        else $error("pass without lock");
endmodule // self_test_checker
bind serial_link_self_test self_test_checker u_chk (.*);
`default_nettype wire

// ==== remote_ser_model.sv ====
// remote serializer model: acks back-channel writes, streams test words
// assumes the block's clock and active-low reset on both sides
`timescale 1ns/100ps
`default_nettype none
module remote_ser_model (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic BC_WR_REQ_OUT,
    input wire logic [7:0] BC_ADDR_OUT,
    input wire logic [7:0] BC_DATA_OUT,
    input wire logic slow,
    input wire logic [1:0] lock_en,
    input wire logic [1:0] corrupt,
    output logic BC_WR_ACK_IN,
    output logic [1:0] RX_LOCK_IN,
    output logic [1:0] RX_VALID_IN,
    output logic [15:0] RX_WORD_IN,
    output logic [7:0] reg14,
    output logic [7:0] bc_err_cnt
);
    logic [7:0] w0, w1;
    logic [2:0] wait_r;
    function automatic logic [7:0] nx(input logic [7:0] w);
        for (int i = 0; i < 8; i++)
            w = {w[6:0], w[6] ^ w[5]};
        return w;
    endfunction
    // outside a run the lines show the inverse, never a stale word
    assign RX_VALID_IN = {2{reg14[0]}};
    assign RX_LOCK_IN = lock_en & RX_VALID_IN;
    assign RX_WORD_IN = reg14[0] ? {w1 ^ {7'h0, corrupt[1]}, w0 ^ {7'h0, corrupt[0]}} : ~{w1, w0};
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            BC_WR_ACK_IN <= 1'b0;
            wait_r <= 3'h0;
            reg14 <= 8'h00;
            bc_err_cnt <= 8'h00;
            w0 <= 8'h5A;
            w1 <= 8'hC3;
        end else begin
            BC_WR_ACK_IN <= 1'b0;
            if (BC_WR_REQ_OUT && !BC_WR_ACK_IN) begin
                wait_r <= wait_r + 3'h1;
                // slow mode answers six cycles late
                if (!slow || wait_r == 3'h5) begin
                    BC_WR_ACK_IN <= 1'b1;
                    wait_r <= 3'h0;
                    if (BC_ADDR_OUT == 8'h14) reg14 <= BC_DATA_OUT;
                    // no crc field here: a frame of the wrong shape stands in for a flagged one
                    if (BC_ADDR_OUT != 8'h14 || BC_DATA_OUT[7:3] != 5'h00)
                        bc_err_cnt <= bc_err_cnt + 8'h01;
                end
            end
            if (reg14[0]) begin
                w0 <= nx(w0);
                w1 <= nx(w1);
            end
        end
    end
endmodule // remote_ser_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the serial link self-test block
// assumes the serializer model and the checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic CLK_IN = 0, RST_N_IN = 0, CE_IN = 1, SELF_TEST_PIN_ENABLE_IN = 0, I2C_WR_IN = 0;
    logic I2C_RD_IN = 0, CC_WR_IN = 0, CC_RD_IN = 0, PASS_PORT_SEL_IN = 0, PATGEN_EN_IN = 0;
    logic RX_MON_IN = 0, BC_WR_ACK_IN, TEST_ACTIVE_OUT, GPIO_PASS_OUT, MONITOR_LINE_OUT;
    logic OUT_EN_OUT, CSI_LP11_OUT, BC_WR_REQ_OUT, slow = 0, dip = 0;
    logic [1:0] CLK_SEL_PINS_IN = 0, RX_LOCK_IN, RX_VALID_IN, LOCK_OUT, PASS_OUT, g;
    logic [1:0] lock_en = 0, corrupt = 0;
    logic [7:0] I2C_ADDR_IN = 0, I2C_WDATA_IN = 0, CC_ADDR_IN = 0, CC_WDATA_IN = 0;
    logic [7:0] I2C_RDATA_OUT, CC_RDATA_OUT, BC_ADDR_OUT, BC_DATA_OUT, reg14, d, bc_err_cnt;
    logic [15:0] RX_WORD_IN;
    int bad_count = 0, check_count = 0, cyc = 0;
    int seed = 32'h7960_c422;
    serial_link_self_test dut (.*);
    remote_ser_model ser (.*);
    initial forever #5 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN) begin
        RX_MON_IN <= 1'($random(seed));
        if (TEST_ACTIVE_OUT && !GPIO_PASS_OUT) dip <= 1'b1;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop;
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic c, input logic w, input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK_IN);
        I2C_ADDR_IN <= a;
        CC_ADDR_IN <= a;
        I2C_WDATA_IN <= v;
        CC_WDATA_IN <= v;
        I2C_WR_IN <= w & !c;
        CC_WR_IN <= w & c;
        I2C_RD_IN <= !w & !c;
        CC_RD_IN <= !w & c;
        @(posedge CLK_IN);
        {I2C_WR_IN, CC_WR_IN, I2C_RD_IN, CC_RD_IN} <= 4'h0;
        @(posedge CLK_IN);
        #1 d = c ? CC_RDATA_OUT : I2C_RDATA_OUT;
    endtask
    task automatic wait_act(input logic v);
        for (int i = 0; i < 300 && TEST_ACTIVE_OUT !== v; i++)
            #10;
        check(TEST_ACTIVE_OUT, v);
    endtask
    task automatic tallies(input logic [7:0] e0, input logic [7:0] e1);
        repeat (20) @(posedge CLK_IN);
        for (int p = 0; p < 2; p++) begin
            acc(p[0], 1, 8'h4C, {3'h0, p[0], 4'h0});
            acc(!p[0], 0, 8'h57, 8'h00);
            check(d, p ? e1 : e0);
        end
    endtask
    // twelve: a bad word also breaks the check of the word after it
    function automatic logic [7:0] want(input int s);
        return s == 0 ? 8'h00 : s == 1 ? 8'h0C : s == 2 ? 8'hFE : 8'hFF;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK_IN);
        RST_N_IN <= 1'b1;
        repeat (4) @(posedge CLK_IN);
        acc(0, 0, 8'hB3, 8'h00);
        check(d, 8'h00);
        acc(1, 1, 8'h20, 8'h5A);
        acc(1, 0, 8'h20, 8'h00);
        check(d, 8'h00);
        acc(1, 1, 8'hB3, 8'hC6);
        acc(0, 0, 8'hB3, 8'h00);
        check(d, 8'hC6);
        // code 3 is fine here: the model is not a parallel-video serializer
        for (int s = 0; s < 4; s++) begin
            lock_en <= 2'h3;
            slow <= s[0];
            PASS_PORT_SEL_IN <= s[1];
            PATGEN_EN_IN <= 1'($random(seed));
            acc(s[0], 1, 8'hB3, {s[1], 4'h0, s[1:0], 1'b1});
            wait_act(1);
            check(reg14, {5'h0, s[1:0], 1'b1});
            repeat (20) @(posedge CLK_IN);
            #1 dip = 1'b0;
            for (int k = 0; k < 300; k++) begin
                @(posedge CLK_IN);
                corrupt[s[1]] <= (s == 2) || (s == 1 && k % 50 == 0);
                if (s == 3 && k == 100) lock_en[s[1]] <= 1'b0;
            end
            @(posedge CLK_IN);
            corrupt <= 2'h0;
            #1 check(dip, 8'(s != 0));
            check(OUT_EN_OUT, s[1]);
            check(CSI_LP11_OUT, !(s[1] && PATGEN_EN_IN));
            acc(s[0], 1, 8'hB3, {s[1], 4'h0, ~s[1:0], 1'b1});
            check(reg14, {5'h0, s[1:0], 1'b1});
            acc(!s[0], 1, 8'hB3, 8'h00);
            wait_act(0);
            tallies(s[1] ? 8'h00 : want(s), s[1] ? want(s) : 8'h00);
            check(reg14, {5'h0, s[1:0], 1'b0});
            $display("register start test %0d done", s);
        end
        g = 2'($random(seed));
        lock_en <= 2'h0;
        CLK_SEL_PINS_IN <= g;
        repeat (4) @(posedge CLK_IN);
        SELF_TEST_PIN_ENABLE_IN <= 1'b1;
        repeat (5) @(posedge CLK_IN);
        CLK_SEL_PINS_IN <= ~g;
        #1 wait_act(1);
        check(reg14, {5'h0, g, 1'b1});
        @(posedge CLK_IN);
        SELF_TEST_PIN_ENABLE_IN <= 1'b0;
        #1 wait_act(0);
        tallies(8'hFF, 8'hFF);
        check(reg14, {5'h0, g, 1'b0});
        check(bc_err_cnt, 8'h00);
        $display("pin start test done");
        // a write taken while the enable is low would start a run
        @(posedge CLK_IN);
        CE_IN <= 1'b0;
        acc(0, 1, 8'hB3, 8'hC5);
        @(posedge CLK_IN);
        CE_IN <= 1'b1;
        acc(0, 0, 8'hB3, 8'h00);
        check(d, 8'h00);
        $display("clock enable test done");
        report_and_stop;
    end
endmodule // tb_top
`default_nettype wire
